// File: logic/stnp_packetizer.sv
// serial byte packetizer with multi-host fan-out and Avalon-MM registers
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
module stnp_packetizer #(
  parameter int MS_CYC = stnp_pkg::MS_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ser_valid,
  input  wire logic [7:0]  ser_data,
  output logic             ser_ready,
  output logic             net_valid,
  output logic      [7:0]  net_data,
  output logic             net_last,
  output logic      [3:0]  net_host_en,
  input  wire logic [3:0]  host_connected,
  input  wire logic [3:0]  host_ready,
  input  wire logic [3:0]  host_stalled,
  input  wire logic [3:0]  host_activity,
  input  wire logic [3:0]  host_cmd_valid,
  input  wire logic [31:0] host_cmd_data,
  output logic      [7:0]  drv_cmd,
  output logic             drv_cmd_valid,
  output logic      [3:0]  conn_close,
  output logic             use_own_serial
);
  import stnp_pkg::*;

  typedef struct packed {
    logic                      wait_n;
    logic [31:0]               rdata;
    logic [2:0]                hosts;
    logic                      skip_en;
    logic                      arb_en;
    stnp_action_t              action;
    logic [10:0]               flush_len;
    logic [7:0]                marker1;
    logic [7:0]                marker2;
    logic [15:0]               idle_ms;
    logic [6:0]                conn_min;
    stnp_state_t               st;
    logic [10:0]               cnt;
    logic [10:0]               frame_len;
    logic [10:0]               rd;
    logic [BUF_BYTES-1:0][7:0] mem;
    logic [17:0]               ms_pre;
    logic [15:0]               ms_cnt;
    logic [1:0]                pend;
    logic                      prev_m1;
    logic [3:0]                set;
    logic [3:0]                done;
    logic                      nvalid;
    logic [7:0]                ndata;
    logic                      nlast;
    logic                      sready;
    logic [7:0]                cmd;
    logic                      cmd_valid;
    logic [22:0]               conn_ms;
    logic [3:0]                close;
    logic                      own_ser;
    logic [15:0]               frames;
  } stnp_state_s_t;

  stnp_state_s_t r;
  stnp_state_s_t next_r;

  function automatic logic multi_host(input logic [2:0] h);
    multi_host = h > 3'h1;
  endfunction

  // hosts allowed to receive: connected and within the allowed count
  function automatic logic [3:0] allowed(input logic [2:0] h,
                                         input logic [3:0] conn);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < h) begin
        m[i] = conn[i];
      end
    end
    allowed = m;
  endfunction

  logic        tick;
  logic        fire;
  logic        flush;
  logic        hit;
  logic [10:0] ncnt;
  logic [3:0]  taken;

  assign tick = r.ms_pre == 18'(MS_CYC - 1);
  assign fire = ser_valid && r.sready;

  always_comb begin
    next_r = r;
    flush = 1'b0;
    hit = 1'b0;
    ncnt = r.cnt;
    taken = 4'h0;
    // bus slave: one wait cycle, then the answer
    next_r.wait_n = 1'b0;
    if ((avs_read || avs_write) && !r.wait_n) begin
      next_r.wait_n = 1'b1;
      next_r.rdata = 32'h0;
      case (avs_address[4:2])
        REG_CTRL:     next_r.rdata = {25'h0, r.action, r.arb_en,
                                      r.skip_en, r.hosts};
        REG_FLUSHLEN: next_r.rdata = {21'h0, r.flush_len};
        REG_MARKERS:  next_r.rdata = {16'h0, r.marker2, r.marker1};
        REG_IDLEMS:   next_r.rdata = {16'h0, r.idle_ms};
        REG_CONNIDLE: next_r.rdata = {25'h0, r.conn_min};
        REG_STATUS:   next_r.rdata = {r.frames, r.set, 1'b0, r.cnt};
        REG_DRVCMD:   next_r.rdata = {24'h0, r.cmd};
        default:      next_r.rdata = 32'h0;
      endcase
    end
    if (avs_write && r.wait_n) begin
      case (avs_address[4:2])
        REG_CTRL: begin
          // clamp host count to one..four
          if (avs_writedata[2:0] == 3'h0) begin
            next_r.hosts = HOSTS_RST;
          end else if (avs_writedata[2:0] > HOSTS_MAX) begin
            next_r.hosts = HOSTS_MAX;
          end else begin
            next_r.hosts = avs_writedata[2:0];
          end
          next_r.skip_en = avs_writedata[3];
          next_r.arb_en = avs_writedata[4];
          next_r.action = stnp_action_t'(avs_writedata[6:5]);
        end
        REG_FLUSHLEN: next_r.flush_len = avs_writedata[10:0];
        REG_MARKERS: begin
          next_r.marker1 = avs_writedata[7:0];
          next_r.marker2 = avs_writedata[15:8];
        end
        REG_IDLEMS:   next_r.idle_ms = avs_writedata[15:0];
        REG_CONNIDLE: next_r.conn_min = avs_writedata[6:0];
        default: ;
      endcase
    end
    next_r.own_ser = multi_host(r.hosts);

    // millisecond tick and serial idle timer
    next_r.ms_pre = tick ? 18'h0 : r.ms_pre + 18'h1;
    if (fire) begin
      next_r.ms_cnt = 16'h0;
    end else if (tick && r.ms_cnt != 16'hffff) begin
      next_r.ms_cnt = r.ms_cnt + 16'h1;
    end

    case (r.st)
      STNP_ACC: begin
        if (fire) begin
          next_r.mem[r.cnt[9:0]] = ser_data;
          ncnt = r.cnt + 11'h1;
          next_r.prev_m1 = ser_data == r.marker1;
          if (r.marker1 == 8'h0) begin
            flush = 1'b1;
          end else if (r.pend != 2'h0) begin
            next_r.pend = r.pend - 2'h1;
            flush = r.pend == 2'h1;
          end else begin
            if (r.marker2 == 8'h0) begin
              hit = ser_data == r.marker1;
            end else begin
              hit = r.prev_m1 && ser_data == r.marker2;
            end
            if (hit) begin
              case (r.action)
                STNP_ACT_PLAIN: flush = 1'b1;
                STNP_ACT_EXT1:  next_r.pend = 2'h1;
                STNP_ACT_EXT2:  next_r.pend = 2'h2;
                STNP_ACT_STRIP: begin
                  ncnt = ncnt - ((r.marker2 == 8'h0) ? 11'h1 : 11'h2);
                  flush = ncnt != 11'h0;
                end
                default: flush = 1'b1;
              endcase
              next_r.prev_m1 = 1'b0;
            end
          end
          if (r.flush_len != 11'h0 && ncnt == r.flush_len) begin
            flush = 1'b1;
          end
          if (ncnt == BUF_FULL) begin
            flush = 1'b1;
          end
          next_r.cnt = ncnt;
        end else if (r.idle_ms != 16'h0 && r.cnt != 11'h0 &&
                     r.ms_cnt >= r.idle_ms) begin
          flush = 1'b1;
        end
        if (flush) begin
          // first condition wins; count, marker state and timer restart
          next_r.st = STNP_START;
          next_r.frame_len = next_r.cnt;
          next_r.cnt = 11'h0;
          next_r.pend = 2'h0;
          next_r.prev_m1 = 1'b0;
          next_r.ms_cnt = 16'h0;
        end else if (fire && ncnt == 11'h0) begin
          next_r.cnt = 11'h0;
        end
      end
      STNP_START: begin
        next_r.rd = 11'h0;
        next_r.done = 4'h0;
        next_r.set = allowed(r.hosts, host_connected);
        // stalled hosts leave before the first byte, not one byte late
        if (r.skip_en && multi_host(r.hosts)) begin
          next_r.set = next_r.set & ~host_stalled;
        end
        next_r.nvalid = 1'b1;
        next_r.ndata = r.mem[0];
        next_r.nlast = r.frame_len == 11'h1;
        next_r.st = STNP_SEND;
      end
      STNP_SEND: begin
        next_r.set = r.set & allowed(r.hosts, host_connected);
        if (r.skip_en && multi_host(r.hosts)) begin
          next_r.set = next_r.set & ~host_stalled;
        end
        taken = r.done | (host_ready & r.set);
        next_r.done = taken;
        // a byte moves on only once the whole set has taken it
        if ((taken & next_r.set) == next_r.set) begin
          next_r.done = 4'h0;
          if (r.nlast) begin
            next_r.nvalid = 1'b0;
            next_r.nlast = 1'b0;
            next_r.frames = r.frames + 16'h1;
            next_r.st = STNP_ACC;
          end else begin
            next_r.rd = r.rd + 11'h1;
            next_r.ndata = r.mem[next_r.rd[9:0]];
            next_r.nlast = next_r.rd == r.frame_len - 11'h1;
          end
        end
      end
      default: next_r.st = STNP_ACC;
    endcase
    next_r.sready = next_r.st == STNP_ACC;

    // driver commands: lowest index wins a same-cycle tie
    next_r.cmd_valid = 1'b0;
    if (r.arb_en || !multi_host(r.hosts)) begin
      for (int i = 3; i >= 0; i--) begin
        if (host_cmd_valid[i] && 3'(i) < r.hosts) begin
          next_r.cmd = host_cmd_data[i*8 +: 8];
          next_r.cmd_valid = 1'b1;
        end
      end
    end

    // connection idle check in whole minutes of millisecond ticks
    next_r.close = 4'h0;
    if (r.conn_min == 7'h0 || (host_activity & host_connected) != 4'h0 ||
        host_connected == 4'h0) begin
      next_r.conn_ms = 23'h0;
    end else if (tick) begin
      if (r.conn_ms + 23'h1 >= 23'(r.conn_min * MS_PER_MIN)) begin
        next_r.close = host_connected;
        next_r.conn_ms = 23'h0;
      end else begin
        next_r.conn_ms = r.conn_ms + 23'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.hosts <= HOSTS_RST;
      r.arb_en <= 1'b1;
      r.conn_min <= CONNIDLE_RST;
      r.action <= STNP_ACT_PLAIN;
      r.st <= STNP_ACC;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = !r.wait_n;
  assign ser_ready = r.sready;
  assign net_valid = r.nvalid;
  assign net_data = r.ndata;
  assign net_last = r.nlast;
  assign net_host_en = r.set;
  assign drv_cmd = r.cmd;
  assign drv_cmd_valid = r.cmd_valid;
  assign conn_close = r.close;
  assign use_own_serial = r.own_ser;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_no_marker_fwd: assert property (
    fire && r.marker1 == 8'h0 |=> r.st == STNP_START ##1 net_valid)
    else $error("byte not forwarded with no marker");
  a_size_limit: assert property (
    fire && r.flush_len != 11'h0 && r.cnt + 11'h1 == r.flush_len
    |=> r.st == STNP_START && r.frame_len == $past(r.flush_len))
    else $error("size limit did not close frame");
  a_full_buffer: assert property (
    fire && r.cnt == BUF_FULL - 11'h1 |=> r.cnt == 11'h0 && !ser_ready)
    else $error("full buffer not flushed");
  a_hold_marker: assert property (
    fire && r.marker1 != 8'h0 && r.pend == 2'h0 && r.flush_len == 11'h0 &&
    ser_data != r.marker1 && ser_data != r.marker2 &&
    r.cnt < BUF_FULL - 11'h1 |=> r.st == STNP_ACC)
    else $error("bytes released without marker");
  a_send_blocks: assert property (
    net_valid && !r.nlast && r.st == STNP_SEND &&
    (host_ready & r.set) != r.set && r.done == 4'h0 &&
    !(r.skip_en && multi_host(r.hosts)) &&
    (r.set & ~allowed(r.hosts, host_connected)) == 4'h0
    |=> $stable(net_data))
    else $error("byte advanced before all hosts took it");
  a_no_rx_send: assert property (
    r.st != STNP_ACC |-> !ser_ready)
    else $error("serial accepted while framing");
  a_cmd_discard: assert property (
    host_cmd_valid != 4'h0 && !r.arb_en && multi_host(r.hosts)
    |=> !drv_cmd_valid)
    else $error("command taken with arbitration off");
  a_idle_off: assert property (
    r.st == STNP_ACC && !fire && r.idle_ms == 16'h0 |=> r.st == STNP_ACC)
    else $error("timeout flush while disabled");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  c_marker_frame: cover property (fire && hit && r.action == STNP_ACT_PLAIN);
  c_strip_frame: cover property (fire && hit && r.action == STNP_ACT_STRIP);
  c_frame_done: cover property (net_valid && net_last ##1 !net_valid);
  c_conn_close: cover property (conn_close != 4'h0);
endmodule

// File: common/stnp_pkg.sv
// constants and types for the serial-to-network packetizer
package stnp_pkg;
  localparam int         BUF_BYTES    = 1024;
  localparam logic [10:0] BUF_FULL    = 11'h400;
  localparam int         CLK_MHZ      = 200;
  localparam int         MS_PER_MIN   = 60000;
  localparam int         MS_CYCLES    = CLK_MHZ * 1000;
  // register word indices, byte address = word index * 4
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_FLUSHLEN = 3'h1;
  localparam logic [2:0] REG_MARKERS  = 3'h2;
  localparam logic [2:0] REG_IDLEMS   = 3'h3;
  localparam logic [2:0] REG_CONNIDLE = 3'h4;
  localparam logic [2:0] REG_STATUS   = 3'h5;
  localparam logic [2:0] REG_DRVCMD   = 3'h6;
  localparam logic [2:0] HOSTS_RST    = 3'h1;
  localparam logic [2:0] HOSTS_MAX    = 3'h4;
  localparam logic [6:0] CONNIDLE_RST = 7'h07;
  typedef enum logic [1:0] {
    STNP_ACT_PLAIN = 2'b00,
    STNP_ACT_EXT1  = 2'b01,
    STNP_ACT_EXT2  = 2'b10,
    STNP_ACT_STRIP = 2'b11
  } stnp_action_t;
  typedef enum logic [1:0] {
    STNP_ACC   = 2'b00,
    STNP_START = 2'b01,
    STNP_SEND  = 2'b10
  } stnp_state_t;
endpackage

// File: dv/stnp_host_model.sv
// readiness model of the four network hosts
`timescale 1ns/10ps
module stnp_host_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       slow,
  input  wire logic [3:0] host_stalled,
  output logic      [3:0] host_ready
);
  logic [7:0] lfsr;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lfsr       <= 8'h5b;
      host_ready <= 4'h0;
    end else begin
      lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      // a stalled host never takes a byte
      host_ready <= ~host_stalled & (slow ? lfsr[3:0] : 4'hf);
    end
  end
endmodule

// File: dv/stnp_packetizer_tb.sv
// self-checking bench with a queue model of frame packing
`timescale 1ns/10ps
module stnp_packetizer_tb;
  import stnp_pkg::*;
  localparam int MSC = 10;
  logic sys_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, host_cmd_data = 32'h0;
  logic avs_waitrequest, ser_valid = 1'b0, ser_ready, net_valid, net_last;
  logic [7:0] ser_data = 8'h0, net_data, drv_cmd;
  logic [3:0] net_host_en, host_ready, conn_close, host_cmd_valid = 4'h0;
  logic [3:0] host_connected = 4'h1, host_stalled = 4'h0;
  logic drv_cmd_valid, use_own_serial, slow = 1'b0;
  logic [31:0] rs = 32'h43c4;
  logic [8:0] w;
  logic [3:0] hd = 4'h0, tk;
  logic [7:0] bq[$];
  logic [8:0] eq[$];
  int m1, m2, act, flen, pend, h1_cnt, mismatches, cmp_count;
  always #2.5 sys_clk = ~sys_clk;
  stnp_packetizer #(.MS_CYC(MSC)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ser_valid(ser_valid),
    .ser_data(ser_data), .ser_ready(ser_ready), .net_valid(net_valid),
    .net_data(net_data), .net_last(net_last), .net_host_en(net_host_en),
    .host_connected(host_connected), .host_ready(host_ready),
    .host_stalled(host_stalled), .host_activity(4'h0),
    .host_cmd_valid(host_cmd_valid), .host_cmd_data(host_cmd_data),
    .drv_cmd(drv_cmd), .drv_cmd_valid(drv_cmd_valid),
    .conn_close(conn_close), .use_own_serial(use_own_serial));
  stnp_host_model hosts (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow),
    .host_stalled(host_stalled), .host_ready(host_ready));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string m);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h want %h", $time, m, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic void emit();
    foreach (bq[i]) eq.push_back({i == bq.size() - 1, bq[i]});
    bq.delete();
    pend = 0;
  endfunction
  // packing model: whichever condition comes first closes the frame
  function automatic void mdl_push(logic [7:0] b);
    logic hit;
    hit = m2 == 0 ? b == m1 : bq.size() > 0 && bq[$] == m1 && b == m2;
    bq.push_back(b);
    if (m1 == 0) emit();
    else if (pend > 0) begin
      pend--;
      if (pend == 0) emit();
    end else if (hit) begin
      if (act == 3) begin
        void'(bq.pop_back());
        if (m2 != 0) void'(bq.pop_back());
        if (bq.size() > 0) emit();
      end else if (act == 0) emit();
      else pend = act;
    end
    if (flen != 0 && bq.size() == flen) emit();
    if (bq.size() == BUF_BYTES) emit();
  endfunction
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(n < 50, 1, "bus answer missing");
  endtask
  task automatic cfg(input logic [31:0] c, input int fl, input logic [7:0] a,
                     input logic [7:0] b, input int ms);
    logic [31:0] v[4];
    v = '{c, fl, {16'h0, b, a}, ms};
    for (int i = 0; i < 4; i++) begin
      av(1'b1, 5'(i * 4), v[i]);
      av(1'b0, 5'(i * 4), 32'h0);
      check(q, v[i], "readback");
    end
    act = c[6:5];
    flen = fl;
    m1 = a;
    m2 = b;
  endtask
  task automatic ser_send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge sys_clk);
    ser_valid <= 1'b1;
    ser_data <= b;
    @(posedge sys_clk);
    while (ser_ready !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    mdl_push(b);
    ser_valid <= 1'b0;
    ser_data <= ~b;
    check(n < 5000, 1, "serial byte not taken");
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (eq.size() != 0 && n < 9000) begin
      @(posedge sys_clk);
      n++;
    end
    check(eq.size(), 0, "frame bytes missing");
  endtask
  task automatic idle_tail(input int ms);
    int n;
    n = 0;
    if (bq.size() > 0) emit();
    while (net_valid !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check(n >= (ms - 1) * MSC && n <= (ms + 1) * MSC + 4, 1, "idle");
    drain();
  endtask
  task automatic send_cmd(input logic [3:0] v, input logic [31:0] d,
                          input logic want);
    @(posedge sys_clk);
    host_cmd_valid <= v;
    host_cmd_data <= d;
    @(posedge sys_clk);
    host_cmd_valid <= 4'h0;
    host_cmd_data <= ~d;
    @(posedge sys_clk);
    check(drv_cmd_valid, want, "command pulse");
  endtask
  // host 0 is the reference receiver; every byte it takes is compared
  // hd: hosts that already took the current byte, so none counts twice
  always @(posedge sys_clk) begin
    tk = hd | (host_ready & net_host_en);
    if (reset_n === 1'b1 && net_valid === 1'b1) begin
      if (net_host_en[1] === 1'b1 && host_ready[1] === 1'b1 && !hd[1])
        h1_cnt++;
      if (net_host_en[0] === 1'b1 && host_ready[0] === 1'b1 && !hd[0]) begin
        w = eq.size() > 0 ? eq.pop_front() : 9'h1ff;
        check({net_last, net_data}, w, "frame byte");
      end
      hd = ((tk & net_host_en) == net_host_en) ? 4'h0 : tk;
    end else begin
      hd = 4'h0;
    end
    if (conn_close !== 4'h0) check(conn_close, 4'h0, "close");
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    check(0, 1, "watchdog expired");
    give_verdict();
  end
  initial begin
    logic [7:0] seq[8];
    seq = '{8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a, 8'h43, 8'h44, 8'h45};
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    av(1'b0, 5'h00, 32'h0);
    check(q, 32'h11, "ctrl reset");
    av(1'b0, 5'h10, 32'h0);
    check(q, 32'h7, "idle minutes reset");
    av(1'b1, 5'h1c, 32'h5a);
    av(1'b0, 5'h1c, 32'h0);
    check(q, 32'h0, "unmapped");
    for (int k = 0; k < 2; k++) begin
      cfg(32'h11, 0, 8'h0, k ? 8'h7e : 8'h0, 0);
      repeat (4) ser_send(8'(rnd()));
      drain();
    end
    for (int a = 0; a < 4; a++) for (int d = 0; d < 2; d++) begin
      cfg({25'h0, 2'(a), 5'h11}, 0, 8'h0d, d ? 8'h0a : 8'h0, 3);
      foreach (seq[i]) ser_send(seq[i]);
      idle_tail(3);
    end
    foreach (seq[i]) begin
      cfg(32'h11, i == 0 ? 1 : 4, 8'hff, 8'h0, 0);
      repeat (10) ser_send(8'(rnd()) & 8'h7f);
      repeat (100) @(posedge sys_clk);
      if (bq.size() > 0) emit();
      if (i == 1) break;
    end
    cfg(32'h11, 4, 8'hff, 8'h0, 3);
    drain();
    slow <= 1'b1;
    cfg(32'h11, 0, 8'hff, 8'h0, 0);
    repeat (BUF_BYTES) ser_send(8'(rnd()) & 8'h7f);
    drain();
    host_connected <= 4'h3;
    cfg(32'h12, 4, 8'hff, 8'h0, 0);
    check(use_own_serial, 1'b1, "own serial");
    h1_cnt = 0;
    repeat (8) ser_send(8'(rnd()) & 8'h7f);
    drain();
    check(h1_cnt, 8, "all hosts served");
    host_stalled <= 4'h2;
    cfg(32'h1a, 4, 8'hff, 8'h0, 0);
    repeat (8) ser_send(8'(rnd()) & 8'h7f);
    drain();
    check(h1_cnt, 8, "stalled host skipped");
    send_cmd(4'h1, 32'h000000c5, 1'b1);
    check(drv_cmd, 8'hc5, "first command");
    send_cmd(4'h2, 32'h00003a00, 1'b1);
    check(drv_cmd, 8'h3a, "latest command");
    cfg(32'h0a, 4, 8'hff, 8'h0, 0);
    send_cmd(4'h1, 32'h00000077, 1'b0);
    give_verdict();
  end
endmodule
